// File: ivps_core.sv
/*
 * Interrupt and reset entry unit: vector selection and context stacking.
 * Assumes the core supplies register bytes and memory accepts one access per cycle.
 */
// Function
// - Vectors are fetched from the region FFCC to FFFF, two bytes each.
// - Priority rises with address; timer A ch5 lowest, then ch4, converter, keyboard.
// - Vector high byte at even address, low byte at following odd address.
// - Async serial port: transmit FFD4, receive FFD6, error FFD8.
// - CAN: transmit FFDA, receive FFDC, error FFDE, wakeup FFE0.
// - SPI transmit FFE2 and receive FFE4, above the CAN vectors.
// - Timer B overflow FFE6, channel 1 FFE8, channel 0 FFEA.
// - Timer A overflow FFEC; channels 3 to 0 at FFEE to FFF4.
// - Five bytes of core registers are pushed before servicing.
// - Index-high register is not saved on interrupt entry.
// - Stack pointer decrements per push, increments per pull.
// - Stack pointer resets to 00FF; reset stack pointer instruction returns it to 00FF.
// - Stack pointer is 16 bits, held in this unit; software can load it through sp_load_in.
`timescale 1ns/100ps
module ivps_core #(
    parameter int NUM_SRC = ivps_pkg::NUM_SRC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Peripheral requests, index per source order
    input wire logic [NUM_SRC-2:0] irq_req_in,
    input wire logic irq_mask_in,
    // Core handshake
    input wire logic [7:0] ctx_byte_in [ivps_pkg::STACK_BYTES],
    input wire logic rsp_instr_in,
    input wire logic pull_in,
    input wire logic [15:0] sp_load_in,
    input wire logic sp_load_en_in,
    input wire logic [7:0] mem_rdata_in,
    // Memory access
    output logic mem_wr_out,
    output logic mem_rd_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    // Entry result
    output logic [15:0] sp_out,
    output logic [15:0] vector_out,
    output logic [ivps_pkg::SRC_W-1:0] src_out,
    output logic busy_out,
    output logic done_out
);
    import ivps_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_SRC != 26) begin : g_bad_src
        $error("ivps_core: vector table is fixed at 26 sources");
    end
    if (SRC_W < $clog2(NUM_SRC)) begin : g_bad_src_w
        $error("ivps_core: source index too narrow");
    end
    if (VEC_RESET != VEC_BASE + 16'(2 * NUM_SRC - 2)) begin : g_bad_reset_vec
        $error("ivps_core: reset vector is not the last table entry");
    end
    if (VEC_TOP != VEC_RESET + 16'h0001) begin : g_bad_top
        $error("ivps_core: table does not end at the top of memory");
    end
    if (STACK_LAST != 3'(STACK_BYTES - 1)) begin : g_bad_stack
        $error("ivps_core: stacked byte count and last index disagree");
    end

    // ------------------------------------------------------------
    // Vector address for a source
    // ------------------------------------------------------------
    function automatic logic [15:0] vec_addr(input logic [SRC_W-1:0] s);
        vec_addr = VEC_BASE + {10'h000, s, 1'b0};
    endfunction

    ivps_state_e state_q, state_d;
    logic [15:0] sp_q, sp_d;
    logic [2:0] cnt_q, cnt_d;
    logic [SRC_W-1:0] src_q, src_d;
    logic [7:0] vec_hi_q, vec_hi_d;
    logic [15:0] vector_q, vector_d;
    logic done_q, done_d;
    logic any_w;
    logic [SRC_W-1:0] idx_w;
    logic [NUM_SRC-1:0] req_w;
    logic [15:0] vaddr_w;
    logic [15:0] fetch_addr_w;
    logic push_last_w;
    logic fetch_low_w;
    logic [15:0] sp_inc_w;
    logic [15:0] sp_dec_w;

    // ------------------------------------------------------------
    // Priority selection
    // ------------------------------------------------------------
    assign req_w = {1'b0, irq_req_in & {(NUM_SRC-1){~irq_mask_in}}};

    ivps_prio_enc #(
        .N(NUM_SRC),
        .W(SRC_W)
    ) u_enc (
        .req_in(req_w),
        .any_out(any_w),
        .idx_out(idx_w)
    );

    assign vaddr_w = vec_addr(src_q);

    // ------------------------------------------------------------
    // Step and stack pointer decode
    // ------------------------------------------------------------
    assign fetch_addr_w = vaddr_w | {15'h0000, cnt_q[0]};
    assign push_last_w = (cnt_q == STACK_LAST);
    assign fetch_low_w = (cnt_q[1:0] == FETCH_LAST);
    assign sp_inc_w = sp_q + 16'h0001;
    assign sp_dec_w = sp_q - 16'h0001;

    // ------------------------------------------------------------
    // Entry sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        sp_d = sp_q;
        cnt_d = cnt_q;
        src_d = src_q;
        vec_hi_d = vec_hi_q;
        vector_d = vector_q;
        done_d = 1'b0;
        mem_wr_out = 1'b0;
        mem_rd_out = 1'b0;
        mem_addr_out = 16'h0000;
        mem_wdata_out = 8'h00;
        case (state_q)
            IVPS_RESET: begin
                src_d = SRC_RESET;
                cnt_d = 3'h0;
                state_d = IVPS_FETCH;
            end
            IVPS_IDLE: begin
                if (rsp_instr_in) begin
                    sp_d = SP_RESET;
                end else if (sp_load_en_in) begin
                    sp_d = sp_load_in;
                end else if (pull_in) begin
                    sp_d = sp_inc_w;
                end
                if (any_w) begin
                    src_d = idx_w;
                    cnt_d = 3'h0;
                    state_d = IVPS_PUSH;
                end
            end
            IVPS_PUSH: begin
                mem_wr_out = 1'b1;
                mem_addr_out = sp_q;
                mem_wdata_out = ctx_byte_in[cnt_q];
                sp_d = sp_dec_w;
                cnt_d = cnt_q + 3'h1;
                if (push_last_w) begin
                    cnt_d = 3'h0;
                    state_d = IVPS_FETCH;
                end
            end
            IVPS_FETCH: begin
                mem_rd_out = 1'b1;
                mem_addr_out = fetch_addr_w;
                cnt_d = cnt_q + 3'h1;
                if (!fetch_low_w) begin
                    vec_hi_d = mem_rdata_in;
                end else begin
                    vector_d = {vec_hi_q, mem_rdata_in};
                    state_d = IVPS_DONE;
                end
            end
            IVPS_DONE: begin
                done_d = 1'b1;
                state_d = IVPS_IDLE;
            end
            default: begin
                state_d = IVPS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_q <= IVPS_RESET;
            cnt_q <= 3'h0;
            src_q <= SRC_RESET;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            src_q <= src_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Stack pointer and vector registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            sp_q <= SP_RESET;
            vec_hi_q <= 8'h00;
            vector_q <= 16'h0000;
        end else begin
            sp_q <= sp_d;
            vec_hi_q <= vec_hi_d;
            vector_q <= vector_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sp_out = sp_q;
    assign vector_out = vector_q;
    assign src_out = src_q;
    assign done_out = done_q;
    assign busy_out = (state_q != IVPS_IDLE);
endmodule

// File: ivps_pkg.sv
/*
 * Package for the interrupt vector, priority and stacking unit.
 * Assumes a single system clock and an 8-bit core with 16-bit addresses.
 */
package ivps_pkg;
    // ------------------------------------------------------------
    // Sources, lowest priority at index 0
    // ------------------------------------------------------------
    localparam int NUM_SRC = 26;
    localparam int SRC_W = 5;
    localparam logic [15:0] VEC_BASE = 16'hFFCC;
    localparam logic [15:0] VEC_TOP = 16'hFFFF;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [4:0] SRC_TIMER_A_CH5 = 5'h00;
    localparam logic [4:0] SRC_TIMER_A_CH4 = 5'h01;
    localparam logic [4:0] SRC_ADC = 5'h02;
    localparam logic [4:0] SRC_KEYBOARD = 5'h03;
    localparam logic [4:0] SRC_SERIAL_TX = 5'h04;
    localparam logic [4:0] SRC_SERIAL_RX = 5'h05;
    localparam logic [4:0] SRC_SERIAL_ERR = 5'h06;
    localparam logic [4:0] SRC_CAN_TX = 5'h07;
    localparam logic [4:0] SRC_CAN_RX = 5'h08;
    localparam logic [4:0] SRC_CAN_ERR = 5'h09;
    localparam logic [4:0] SRC_CAN_WAKE = 5'h0A;
    localparam logic [4:0] SRC_SPI_TX = 5'h0B;
    localparam logic [4:0] SRC_SPI_RX = 5'h0C;
    localparam logic [4:0] SRC_TIMER_B_OVF = 5'h0D;
    localparam logic [4:0] SRC_TIMER_B_CH1 = 5'h0E;
    localparam logic [4:0] SRC_TIMER_B_CH0 = 5'h0F;
    localparam logic [4:0] SRC_TIMER_A_OVF = 5'h10;
    localparam logic [4:0] SRC_TIMER_A_CH3 = 5'h11;
    localparam logic [4:0] SRC_TIMER_A_CH2 = 5'h12;
    localparam logic [4:0] SRC_TIMER_A_CH1 = 5'h13;
    localparam logic [4:0] SRC_TIMER_A_CH0 = 5'h14;
    localparam logic [4:0] SRC_PERIODIC_TIMER = 5'h15;
    localparam logic [4:0] SRC_PLL = 5'h16;
    localparam logic [4:0] SRC_EXTERNAL_IRQ_PIN = 5'h17;
    localparam logic [4:0] SRC_SOFTWARE_INTERRUPT = 5'h18;
    localparam logic [4:0] SRC_RESET = 5'h19;
    // ------------------------------------------------------------
    // Stack
    // ------------------------------------------------------------
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam int STACK_BYTES = 5;
    localparam logic [2:0] STACK_LAST = 3'h4;
    localparam logic [1:0] FETCH_LAST = 2'h1;
    // ------------------------------------------------------------
    // Entry sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        IVPS_IDLE = 5'b00001,
        IVPS_PUSH = 5'b00010,
        IVPS_FETCH = 5'b00100,
        IVPS_DONE = 5'b01000,
        IVPS_RESET = 5'b10000
    } ivps_state_e;
endpackage

// File: ivps_prio_enc.sv
/*
 * Fixed priority encoder: highest set index wins.
 * Assumes requests are already synchronous to the system clock.
 */
`timescale 1ns/100ps
module ivps_prio_enc #(
    parameter int N = ivps_pkg::NUM_SRC,
    parameter int W = ivps_pkg::SRC_W
) (
    // Requests
    input wire logic [N-1:0] req_in,
    // Result
    output logic any_out,
    output logic [W-1:0] idx_out
);
    import ivps_pkg::*;

    if (N > (1 << W)) begin : g_bad_width
        $error("ivps_prio_enc: index width too small");
    end

    always_comb begin
        idx_out = '0;
        for (int i = 0; i < N; i++) begin
            if (req_in[i]) begin
                idx_out = W'(i);
            end
        end
    end

    assign any_out = |req_in;
endmodule

// File: ivps_core_assertions.sv
/* Port checker for the entry unit.
   Bound to ivps_core; sees its ports only. */
`timescale 1ns/100ps
module ivps_core_assertions (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Watched ports
    input wire logic mem_wr_out,
    input wire logic mem_rd_out,
    input wire logic [15:0] mem_addr_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [15:0] sp_out,
    input wire logic [15:0] vector_out,
    input wire logic done_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    vec_range_a:
        assert property (mem_rd_out |-> mem_addr_out >= 16'hFFCC) else $error("read low");
    pair_addr_a:
        assert property (mem_rd_out && !mem_addr_out[0] |=> mem_rd_out
            && mem_addr_out == $past(mem_addr_out) + 16'h0001) else $error("pair split");
    push_five_a:
        assert property ($rose(mem_wr_out) |-> mem_wr_out[*5] ##1 !mem_wr_out)
        else $error("push count");
    push_dec_a:
        assert property (mem_wr_out && $past(mem_wr_out) |->
            mem_addr_out == $past(mem_addr_out) - 16'h0001) else $error("push addr");
    sp_entry_a:
        assert property ($rose(mem_wr_out) |-> ##8
            sp_out == $past(mem_addr_out, 8) - 16'h0005) else $error("sp after entry");
    sp_reset_a:
        assert property ($rose(nrst_in) |-> sp_out == 16'h00FF) else $error("sp reset");
    reset_fetch_a:
        assert property ($rose(nrst_in) |-> ##[0:2] (mem_rd_out && mem_addr_out == 16'hFFFE))
        else $error("reset fetch");
    done_vec_a:
        assert property (done_out |-> vector_out ==
            {$past(mem_rdata_in, 3), $past(mem_rdata_in, 2)}) else $error("vector bytes");
endmodule

bind ivps_core ivps_core_assertions u_chk (.mclk_in, .nrst_in, .mem_wr_out, .mem_rd_out,
    .mem_addr_out, .mem_rdata_in, .sp_out, .vector_out, .done_out);

// File: ivps_mem_model.sv
/* Memory partner: stack RAM and vector bytes.
   Assumes one access per cycle from the entry unit. */
`timescale 1ns/100ps
module ivps_mem_model (
    // Access
    input wire logic clk_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] ram [256];
    logic [7:0] junk_q = 8'h00;
    always_ff @(posedge clk_in) begin
        junk_q <= {junk_q[6:0], ~junk_q[7]};
        if (wr_in) begin
            ram[addr_in[7:0]] <= wdata_in;
        end
    end
    // Byte per address, changing junk when idle
    assign rdata_out = rd_in ? (addr_in[7:0] ^ 8'h5A) : junk_q;
endmodule

// File: tb_interrupt_vector_priority_stacking.sv
/* Testbench for the entry unit.
   Uses the memory model as the far side. */
`timescale 1ns/100ps
module tb_interrupt_vector_priority_stacking;
    import ivps_pkg::*;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [24:0] req = '0;
    logic mask = 1'b0;
    logic rsp = 1'b0;
    logic pull = 1'b0;
    logic ld = 1'b0;
    logic [15:0] ldv = 16'h0000;
    logic [7:0] ctx [STACK_BYTES] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    logic wr, rd, busy, done;
    logic [15:0] addr, sp, vec;
    logic [7:0] wdata, rdata;
    logic [4:0] src;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    ivps_core dut (.mclk_in, .nrst_in, .irq_req_in(req), .irq_mask_in(mask), .ctx_byte_in(ctx),
        .rsp_instr_in(rsp), .pull_in(pull), .sp_load_in(ldv), .sp_load_en_in(ld),
        .mem_rdata_in(rdata), .mem_wr_out(wr), .mem_rd_out(rd), .mem_addr_out(addr),
        .mem_wdata_out(wdata), .sp_out(sp), .vector_out(vec), .src_out(src),
        .busy_out(busy), .done_out(done));
    ivps_mem_model mem (.clk_in(mclk_in), .wr_in(wr), .rd_in(rd), .addr_in(addr),
        .wdata_in(wdata), .rdata_out(rdata));
    initial begin
        forever #2 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] vexp(input logic [15:0] a);
        return {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
    endfunction
    task automatic tick();
        @(posedge mclk_in);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (done !== 1'b1 && n < 40);
        samples_checked++;
        if (done !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t entry did not finish", $time);
        end
    endtask
    task automatic t_reset();
        wait_done();
        chk(vec, vexp(16'hFFFE));
        chk(16'(src), 16'h0019);
        chk(sp, 16'h00FF);
        $display("reset entry finished");
    endtask
    task automatic t_each();
        for (int i = 0; i < 25; i++) begin
            req[i] = 1'b1;
            wait_done();
            req[i] = 1'b0;
            chk(vec, vexp(16'hFFCC + 16'(2 * i)));
            chk(16'(src), 16'(i));
            chk(sp, 16'h00FA);
            for (int k = 0; k < 5; k++) begin
                chk(16'(mem.ram[8'(255 - k)]), 16'(ctx[k]));
            end
            pulse(rsp);
        end
        $display("every source finished");
    endtask
    task automatic t_prio();
        mask = 1'b1;
        req = '1;
        repeat (4) tick();
        chk(16'(busy), 16'h0000);
        mask = 1'b0;
        wait_done();
        chk(16'(src), 16'h0018);
        req = 25'h0000003;
        wait_done();
        chk(16'(src), 16'h0001);
        req = '0;
        $display("priority finished");
    endtask
    task automatic t_sp();
        tick();
        ldv = 16'h8123;
        pulse(ld);
        pulse(pull);
        chk(sp, 16'h8124);
        pulse(rsp);
        chk(sp, 16'h00FF);
        $display("stack pointer finished");
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_in);
        #1;
        nrst_in = 1'b1;
        t_reset();
        t_each();
        t_prio();
        t_sp();
        results();
    end
endmodule
